// >>> core/nvm_port_params.svh
`ifndef NVM_PORT_PARAMS_SVH
`define NVM_PORT_PARAMS_SVH
// action select codes on a load clock pulse
`define ACT_ADDR        2'b00
`define ACT_DATA        2'b01
`define ACT_CMD         2'b10
// byte select codes
`define BSEL_LOW        2'b00
`define BSEL_HIGH       2'b01
`define BSEL_EXT        2'b10
`define BSEL_FUSE_HIGH  2'b11
// command bytes
`define CMD_NOP         8'h00
`define CMD_ERASE       8'h80
`define CMD_WR_FUSE     8'h40
`define CMD_WR_LOCK     8'h20
`define CMD_WR_FLASH    8'h10
`define CMD_WR_EEPROM   8'h11
`define CMD_RD_SIG      8'h08
`define CMD_RD_FUSE     8'h04
`define CMD_RD_FLASH    8'h02
`define CMD_RD_EEPROM   8'h03
// page geometry, largest parts
`define FLASH_PAGE_WORDS 128
`define WORD_BITS        7
`define EE_PAGE_BYTES    8
`define EE_BYTE_BITS     3
`define FLASH_AW         16
`define EE_AW            12
// fuse bit that keeps eeprom on erase (0 = programmed)
`define KEEP_EE_BIT      3
// erased / reset values
`define ERASED_BYTE      8'hFF
`define FUSE_LOW_RST     8'hFF
`define FUSE_HIGH_RST    8'hFF
`define FUSE_EXT_RST     8'hFF
`define LOCK_RST         8'hFF
`define CALIB_RST        8'h80
// timing: mode entry quiet time and settling, device busy times
`define ENTRY_QUIET_NS   100
`define CLK_NS           40
`define ENTRY_QUIET_CYC  ((`ENTRY_QUIET_NS + `CLK_NS - 1) / `CLK_NS)
`define LOAD_CLK_TOGGLES 6
`define PAGE_BUSY_CYC    128
`define ERASE_BUSY_CYC   256
`endif

// >>> core/nvm_port_pkg.sv
package nvm_port_pkg;
    // pins sampled from the programmer
    typedef struct packed {
        logic       load_clock_pin;
        logic       clock_action_sel1;
        logic       clock_action_sel0;
        logic       byte_sel_hi;
        logic       byte_sel_lo;
        logic       page_latch_strobe;
        logic       write_b;
        logic       out_enable_b;
        logic       hv_reset;
    } prog_pins_t;
    typedef enum logic [4:0] {
        ST_OFF   = 5'b00001,
        ST_ENTRY = 5'b00010,
        ST_READY = 5'b00100,
        ST_BUSY  = 5'b01000,
        ST_FAIL  = 5'b10000
    } prog_state_t;
    typedef enum logic [3:0] {
        OP_NONE   = 4'b0001,
        OP_ERASE  = 4'b0010,
        OP_PAGE   = 4'b0100,
        OP_SINGLE = 4'b1000
    } prog_op_t;
endpackage : nvm_port_pkg

// >>> core/nvm_prog_port.sv
`timescale 1ns/100ps
`include "nvm_port_params.svh"
module nvm_prog_port
    import nvm_port_pkg::*;
(
    // clock and reset
    input  wire logic                    clock,
    input  wire logic                    rst_b,
    // programmer pins, asynchronous
    input  wire nvm_port_pkg::prog_pins_t pins,
    input  wire logic [7:0]              data_in,
    // data bus drive
    output logic [7:0]                   data_out,
    output logic                         data_oe,
    // status
    output logic                         prog_ready_flag,
    output logic                         prog_mode
);
    import nvm_port_pkg::*;

    // two-stage synchronisers; stage one read only by stage two
    prog_pins_t pins_s1_q, pins_s2_q, pins_s3_q;
    logic [7:0] data_s1_q, data_s2_q;
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            pins_s1_q <= '0;
            pins_s2_q <= '0;
            pins_s3_q <= '0;
            data_s1_q <= 8'h00;
            data_s2_q <= 8'h00;
        end else begin
            pins_s1_q <= pins;
            pins_s2_q <= pins_s1_q;
            pins_s3_q <= pins_s2_q;
            data_s1_q <= data_in;
            data_s2_q <= data_s1_q;
        end
    end

    // edge detection on synchronised strobes
    wire       xclk_rise  = pins_s2_q.load_clock_pin & ~pins_s3_q.load_clock_pin;
    wire       xclk_edge  = pins_s2_q.load_clock_pin ^ pins_s3_q.load_clock_pin;
    wire       latch_rise = pins_s2_q.page_latch_strobe & ~pins_s3_q.page_latch_strobe;
    wire       wr_fall    = ~pins_s2_q.write_b & pins_s3_q.write_b;
    wire       hv_rise    = pins_s2_q.hv_reset & ~pins_s3_q.hv_reset;
    wire [1:0] action     = {pins_s2_q.clock_action_sel1, pins_s2_q.clock_action_sel0};
    wire [1:0] bsel       = {pins_s2_q.byte_sel_hi, pins_s2_q.byte_sel_lo};
    wire [3:0] entry_pins = {pins_s2_q.page_latch_strobe, pins_s2_q.clock_action_sel1,
                             pins_s2_q.clock_action_sel0, pins_s2_q.byte_sel_lo};

    // memories
    logic [15:0] flash_mem [0:(1 << `FLASH_AW) - 1];
    logic [7:0]  ee_mem    [0:(1 << `EE_AW) - 1];
    logic [15:0] page_buf  [0:`FLASH_PAGE_WORDS - 1];
    logic [7:0]  ee_buf    [0:`EE_PAGE_BYTES - 1];

    // held state
    prog_state_t state_q, state_d;
    prog_op_t    op_q;
    logic [7:0]  cmd_q, addr_lo_q, addr_hi_q, addr_ext_q, data_lo_q, data_hi_q;
    logic [7:0]  fuse_lo_q, fuse_hi_q, fuse_ext_q, lock_q, wr_byte_q;
    logic [1:0]  wr_bsel_q;
    logic [2:0]  toggles_q;
    logic [7:0]  quiet_q;
    logic [15:0] busy_q;
    logic [16:0] sweep_q;
    logic        ee_keep_q;

    // command decode; unknown bytes decode to nothing
    wire is_erase  = cmd_q == `CMD_ERASE;
    wire is_wfuse  = cmd_q == `CMD_WR_FUSE;
    wire is_wlock  = cmd_q == `CMD_WR_LOCK;
    wire is_wflash = cmd_q == `CMD_WR_FLASH;
    wire is_wee    = cmd_q == `CMD_WR_EEPROM;
    wire is_rsig   = cmd_q == `CMD_RD_SIG;
    wire is_rfuse  = cmd_q == `CMD_RD_FUSE;
    wire is_rflash = cmd_q == `CMD_RD_FLASH;
    wire is_ree    = cmd_q == `CMD_RD_EEPROM;

    // addresses: low byte top bit joins page number
    wire [15:0] flash_addr = {addr_hi_q, addr_lo_q};
    wire [6:0]  word_in_page_bits = flash_addr[`WORD_BITS-1:0];
    // word addresses of the largest flash fit in 16 bits; the extended byte adds no page bit
    wire [8:0]  page_number_bits  = flash_addr[15:`WORD_BITS];
    wire [11:0] eeprom_addr_bits  = {addr_hi_q[3:0], addr_lo_q};
    wire [2:0]  ee_byte = eeprom_addr_bits[`EE_BYTE_BITS-1:0];
    wire [8:0]  ee_page = eeprom_addr_bits[11:`EE_BYTE_BITS];

    wire in_ready  = state_q == ST_READY;
    wire load_hit  = in_ready & xclk_rise;
    // write strobe picks an operation; reserved codes start nothing
    wire start_erase = in_ready & wr_fall & is_erase;
    wire start_page  = in_ready & wr_fall & (is_wflash | is_wee) & (bsel == `BSEL_LOW);
    wire start_fuse  = in_ready & wr_fall & is_wfuse & (bsel != `BSEL_FUSE_HIGH);
    wire start_lock  = in_ready & wr_fall & is_wlock;
    wire start_any   = start_erase | start_page | start_fuse | start_lock;
    wire busy_done   = busy_q == 16'h0000;

    // mode entry and busy sequencing
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_OFF:   if (hv_rise && toggles_q == 3'(`LOAD_CLK_TOGGLES) && entry_pins == 4'h0)
                          state_d = ST_ENTRY;
            ST_ENTRY: if (entry_pins != 4'h0) state_d = ST_FAIL;
                      else if (quiet_q == 8'(`ENTRY_QUIET_CYC)) state_d = ST_READY;
            ST_READY: if (start_any) state_d = ST_BUSY;
            ST_BUSY:  if (busy_done) state_d = ST_READY;
            ST_FAIL:  state_d = ST_FAIL;
            default:  state_d = ST_OFF;
        endcase
        if (!pins_s2_q.hv_reset) state_d = ST_OFF;
    end
    // entry counters: toggles while reset low, quiet time after high voltage
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            state_q   <= ST_OFF;
            toggles_q <= 3'h0;
            quiet_q   <= 8'h00;
        end else begin
            state_q <= state_d;
            if (state_q == ST_OFF && xclk_edge && toggles_q != 3'(`LOAD_CLK_TOGGLES))
                toggles_q <= toggles_q + 3'h1;
            else if (state_q != ST_OFF)
                toggles_q <= 3'h0;
            quiet_q <= (state_q == ST_ENTRY) ? quiet_q + 8'h01 : 8'h00;
        end
    end

    // load registers; command and address persist until reloaded
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            cmd_q <= `CMD_NOP;
            addr_lo_q <= 8'h00;
            addr_hi_q <= 8'h00;
            addr_ext_q <= 8'h00;
            data_lo_q <= 8'h00;
            data_hi_q <= 8'h00;
        end else if (load_hit) begin
            case (action)
                `ACT_ADDR: case (bsel)
                    `BSEL_LOW:  addr_lo_q  <= data_s2_q;
                    `BSEL_HIGH: addr_hi_q  <= data_s2_q;
                    `BSEL_EXT:  addr_ext_q <= data_s2_q;
                    default:    ;
                endcase
                `ACT_DATA: if (pins_s2_q.byte_sel_lo) data_hi_q <= data_s2_q;
                           else data_lo_q <= data_s2_q;
                `ACT_CMD:  cmd_q <= data_s2_q;
                default:   ;
            endcase
        end
    end

    // page buffers; no-op command clears the write state
    wire nop_load = load_hit & (action == `ACT_CMD) & (data_s2_q == `CMD_NOP);
    genvar gi;
    generate
        for (gi = 0; gi < `FLASH_PAGE_WORDS; gi++) begin : g_pbuf
            always_ff @(posedge clock) begin
                if (!rst_b || nop_load)
                    page_buf[gi] <= {`ERASED_BYTE, `ERASED_BYTE};
                else if (in_ready && latch_rise && pins_s2_q.byte_sel_lo && is_wflash
                         && word_in_page_bits == 7'(gi))
                    page_buf[gi] <= {data_hi_q, data_lo_q};
            end
        end
        for (gi = 0; gi < `EE_PAGE_BYTES; gi++) begin : g_ebuf
            always_ff @(posedge clock) begin
                if (!rst_b || nop_load)
                    ee_buf[gi] <= `ERASED_BYTE;
                else if (in_ready && latch_rise && is_wee && ee_byte == 3'(gi))
                    ee_buf[gi] <= data_lo_q;
            end
        end
    endgenerate

    // busy timing, operation kind and the memory sweep
    wire erase_flash_done = sweep_q[16];
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            op_q <= OP_NONE;
            busy_q <= 16'h0000;
            sweep_q <= 17'h0_0000;
            ee_keep_q <= 1'b0;
            wr_bsel_q <= `BSEL_LOW;
            wr_byte_q <= 8'h00;
        end else if (start_any) begin
            op_q <= start_erase ? OP_ERASE : start_page ? OP_PAGE : OP_SINGLE;
            busy_q <= start_erase ? 16'(`ERASE_BUSY_CYC) : 16'(`PAGE_BUSY_CYC);
            sweep_q <= 17'h0_0000;
            ee_keep_q <= ~fuse_hi_q[`KEEP_EE_BIT];
            wr_bsel_q <= bsel;
            wr_byte_q <= data_lo_q;
        end else if (state_q == ST_BUSY) begin
            // erase holds busy until the whole flash has been swept
            if (op_q != OP_ERASE || erase_flash_done)
                busy_q <= busy_done ? 16'h0000 : busy_q - 16'h0001;
            if (op_q == OP_ERASE && !erase_flash_done)
                sweep_q <= sweep_q + 17'h0_0001;
            if (busy_done)
                op_q <= OP_NONE;
        end
    end

    // memory writes: one flash word per cycle during erase, page copy one entry per cycle as busy_q counts down to zero
    always_ff @(posedge clock) begin
        if (state_q == ST_BUSY && op_q == OP_ERASE && !erase_flash_done) begin
            flash_mem[sweep_q[15:0]] <= {`ERASED_BYTE, `ERASED_BYTE};
            if (!ee_keep_q)
                ee_mem[sweep_q[`EE_AW-1:0]] <= `ERASED_BYTE;
        end
        if (state_q == ST_BUSY && op_q == OP_PAGE && busy_q[15:7] == 9'h000 && is_wflash)
            flash_mem[{page_number_bits, busy_q[6:0]}] <= page_buf[busy_q[6:0]];
        if (state_q == ST_BUSY && op_q == OP_PAGE && busy_q[15:3] == 13'h0000 && is_wee)
            ee_mem[{ee_page, busy_q[2:0]}] <= ee_buf[busy_q[2:0]];
    end

    // fuses and locks; locks released only after the flash sweep ends
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            fuse_lo_q <= `FUSE_LOW_RST;
            fuse_hi_q <= `FUSE_HIGH_RST;
            fuse_ext_q <= `FUSE_EXT_RST;
            lock_q <= `LOCK_RST;
        end else if (state_q == ST_BUSY && busy_done) begin
            case (op_q)
                OP_ERASE:  lock_q <= `LOCK_RST;
                OP_SINGLE: if (is_wlock) lock_q <= lock_q & wr_byte_q;
                           else if (wr_bsel_q == `BSEL_LOW) fuse_lo_q <= wr_byte_q;
                           else if (wr_bsel_q == `BSEL_HIGH) fuse_hi_q <= wr_byte_q;
                           else fuse_ext_q <= wr_byte_q;
                default:   ;
            endcase
        end
    end

    // read data selection
    wire [15:0] flash_word = flash_mem[flash_addr];
    wire [7:0]  sig_byte   = pins_s2_q.byte_sel_lo ? `CALIB_RST : 8'h00;
    wire [7:0]  fuse_view  = (bsel == `BSEL_LOW) ? fuse_lo_q :
                             (bsel == `BSEL_HIGH) ? lock_q :
                             (bsel == `BSEL_EXT) ? fuse_ext_q : fuse_hi_q;
    wire [7:0]  rd_sel     = is_rflash ? (pins_s2_q.byte_sel_lo ? flash_word[15:8] : flash_word[7:0]) :
                             is_ree    ? ee_mem[eeprom_addr_bits] :
                             is_rfuse  ? fuse_view :
                             is_rsig   ? sig_byte : `ERASED_BYTE;

    // output register; bus driven only while output enable held low
    always_ff @(posedge clock) begin
        if (!rst_b) data_out <= 8'h00;
        else data_out <= rd_sel;
    end
    assign data_oe = in_ready & ~pins_s2_q.out_enable_b;
    assign prog_ready_flag = state_q != ST_BUSY;
    assign prog_mode = state_q == ST_READY || state_q == ST_BUSY;
endmodule : nvm_prog_port

// >>> bench/nvm_port_sva.sv
`timescale 1ns/100ps
`include "nvm_port_params.svh"
module nvm_port_sva
    import nvm_port_pkg::*;
(
    // clock and reset
    input wire logic                     clock,
    input wire logic                     rst_b,
    // watched ports
    input wire nvm_port_pkg::prog_pins_t pins,
    input wire logic [7:0]               data_in,
    input wire logic [7:0]               data_out,
    input wire logic                     data_oe,
    input wire logic                     prog_ready_flag,
    input wire logic                     prog_mode
);
    // longest busy is the erase sweep plus tail; a counter avoids a huge delay range
    localparam int BUSY_MAX = 65536 + 257 + 8;
    logic [17:0] busy_cnt_q;
    logic [17:0] busy_cnt_d;
    assign busy_cnt_d = prog_ready_flag ? 18'h0_0000 : busy_cnt_q + 18'h0_0001;
    always_ff @(posedge clock) begin
        busy_cnt_q <= rst_b ? busy_cnt_d : 18'h0_0000;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    // busy begins, and the write strobe that must have caused it
    sequence busy_start;
        $fell(prog_ready_flag);
    endsequence
    sequence write_seen;
        !$past(pins.write_b, 3) || !$past(pins.write_b, 4) || !$past(pins.write_b, 5);
    endsequence
    a_reset_clears: assert property (disable iff (1'b0) !rst_b |=> prog_ready_flag && !data_oe && !prog_mode)
        else $error("outputs not at reset values");
    a_oe_cause: assert property (data_oe |-> !$past(pins.out_enable_b, 2))
        else $error("bus driven without output enable");
    a_oe_in_mode: assert property (data_oe |-> prog_mode)
        else $error("bus driven outside programming mode");
    a_busy_in_mode: assert property (!prog_ready_flag |-> prog_mode)
        else $error("busy outside programming mode");
    a_busy_cause: assert property (busy_start |-> write_seen)
        else $error("busy without a write strobe");
    a_busy_min: assert property (busy_start |-> !prog_ready_flag [*8])
        else $error("busy ended too early");
    a_busy_bound: assert property (busy_cnt_q <= BUSY_MAX)
        else $error("busy lasted too long");
    a_mode_entry: assert property ($rose(prog_mode) |-> $past(pins.hv_reset, 2) && $past(pins.hv_reset, 3))
        else $error("mode entered without high voltage settled");
endmodule : nvm_port_sva

// >>> bench/nvm_programmer.sv
`timescale 1ns/100ps
module nvm_programmer
    import nvm_port_pkg::*;
(
    // clock
    input wire logic                 clock,
    // device side
    input wire logic [7:0]           data_out,
    input wire logic                 data_oe,
    output nvm_port_pkg::prog_pins_t pins,
    output logic [7:0]               data_in
);
    logic [7:0] drv;
    logic       drv_en;
    // wire level: an undriven bus shows the inverse of its last value, never a friendly one
    assign data_in = data_oe ? data_out : (drv_en ? drv : ~drv);
    initial begin
        pins = '0;
        pins.write_b = 1'b1;
        pins.out_enable_b = 1'b1;
        drv = 8'h00;
        drv_en = 1'b1;
    end
    task automatic idle(input int n);
        repeat (n) @(negedge clock);
    endtask : idle
    // one load clock pulse, half of the 320 ns period high
    task automatic load(input logic [1:0] act, input logic [1:0] bsel, input logic [7:0] val);
        @(negedge clock);
        {pins.clock_action_sel1, pins.clock_action_sel0} = act;
        {pins.byte_sel_hi, pins.byte_sel_lo} = bsel;
        drv = val;
        idle(4);
        pins.load_clock_pin = 1'b1;
        idle(4);
        pins.load_clock_pin = 1'b0;
    endtask : load
    task automatic latch();
        @(negedge clock);
        pins.byte_sel_lo = 1'b1;
        idle(4);
        pins.page_latch_strobe = 1'b1;
        idle(4);
        pins.page_latch_strobe = 1'b0;
    endtask : latch
    task automatic write_pulse(input logic [1:0] bsel);
        @(negedge clock);
        {pins.byte_sel_hi, pins.byte_sel_lo} = bsel;
        idle(4);
        pins.write_b = 1'b0;
        idle(4);
        pins.write_b = 1'b1;
        idle(4);
    endtask : write_pulse
    // release the bus before asking the device to drive it
    task automatic read(input logic [1:0] bsel, output logic [7:0] val);
        @(negedge clock);
        {pins.byte_sel_hi, pins.byte_sel_lo} = bsel;
        drv_en = 1'b0;
        pins.out_enable_b = 1'b0;
        idle(6);
        val = data_in;
        pins.out_enable_b = 1'b1;
        idle(2);
        drv_en = 1'b1;
        idle(2);
    endtask : read
    // disturb moves a strobe inside the quiet time, which must cost the mode entry
    task automatic enter(input logic disturb);
        @(negedge clock);
        pins.hv_reset = 1'b0;
        repeat (6) begin
            pins.load_clock_pin = 1'b1;
            idle(4);
            pins.load_clock_pin = 1'b0;
            idle(4);
        end
        {pins.page_latch_strobe, pins.clock_action_sel1, pins.clock_action_sel0, pins.byte_sel_lo} = 4'h0;
        idle(3);
        pins.hv_reset = 1'b1;
        if (disturb) begin
            idle(1);
            pins.page_latch_strobe = 1'b1;
            idle(8);
            pins.page_latch_strobe = 1'b0;
        end
        idle(1250);
    endtask : enter
endmodule : nvm_programmer

// >>> bench/testbench.sv
`timescale 1ns/100ps
`include "nvm_port_params.svh"
module testbench;
    import nvm_port_pkg::*;
    localparam int CYCLE_LIMIT = 80000;
    logic       clock;
    logic       rst_b;
    prog_pins_t pins;
    logic [7:0] data_in;
    logic [7:0] data_out;
    logic       data_oe;
    logic       prog_ready_flag;
    logic       prog_mode;
    int         n_fail;
    int         total_checks;
    int         cycles;
    logic [7:0] cmds [9];
    nvm_prog_port nvm_prog_port_inst (.clock(clock), .rst_b(rst_b), .pins(pins), .data_in(data_in),
        .data_out(data_out), .data_oe(data_oe), .prog_ready_flag(prog_ready_flag), .prog_mode(prog_mode));
    nvm_programmer nvm_programmer_inst (.clock(clock), .data_out(data_out), .data_oe(data_oe),
        .pins(pins), .data_in(data_in));
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic complete_run();
        if (n_fail == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : complete_run
    task automatic flags(input logic [7:0] exp);
        check("mode ready oe", {5'h00, prog_mode, prog_ready_flag, data_oe}, exp);
    endtask : flags
    // bounded wait for the device to report ready again
    task automatic wait_ready(input int limit);
        for (int i = 0; i < limit && prog_ready_flag !== 1'b1; i++) @(negedge clock);
        check("ready after busy", {7'h00, prog_ready_flag}, 8'h01);
    endtask : wait_ready
    task automatic rd_check(input logic [1:0] bsel, input logic [7:0] exp, input string what);
        logic [7:0] v;
        nvm_programmer_inst.read(bsel, v);
        check(what, v, exp);
    endtask : rd_check
    // hang guard
    always @(posedge clock) begin
        cycles++;
        if (cycles > CYCLE_LIMIT) begin
            n_fail++;
            complete_run();
        end
    end
    initial begin
        n_fail = 0;
        total_checks = 0;
        cycles = 0;
        cmds = '{`CMD_ERASE, `CMD_WR_FUSE, `CMD_WR_LOCK, `CMD_WR_FLASH, `CMD_WR_EEPROM,
                 `CMD_RD_SIG, `CMD_RD_FUSE, `CMD_RD_FLASH, `CMD_RD_EEPROM};
        rst_b = 1'b0;
        repeat (4) @(negedge clock);
        flags(8'h02);
        rst_b = 1'b1;
        nvm_programmer_inst.enter(1'b0);
        flags(8'h06);
        // every command except the no-op loads without starting anything
        foreach (cmds[i]) nvm_programmer_inst.load(`ACT_CMD, `BSEL_LOW, cmds[i]);
        flags(8'h06);
        nvm_programmer_inst.load(`ACT_CMD, `BSEL_LOW, `CMD_ERASE);
        nvm_programmer_inst.write_pulse(`BSEL_LOW);
        flags(8'h04);
        wait_ready(70000);
        // one word into the second page: top bit of the low address picks the page
        nvm_programmer_inst.load(`ACT_CMD, `BSEL_LOW, `CMD_WR_FLASH);
        nvm_programmer_inst.load(`ACT_ADDR, `BSEL_LOW, 8'h85);
        nvm_programmer_inst.load(`ACT_DATA, `BSEL_LOW, 8'h34);
        nvm_programmer_inst.load(`ACT_DATA, `BSEL_HIGH, 8'h12);
        nvm_programmer_inst.latch();
        nvm_programmer_inst.write_pulse(`BSEL_LOW);
        flags(8'h04);
        wait_ready(200);
        nvm_programmer_inst.load(`ACT_CMD, `BSEL_LOW, `CMD_RD_FLASH);
        rd_check(`BSEL_LOW, 8'h34, "flash low byte");
        rd_check(`BSEL_HIGH, 8'h12, "flash high byte");
        nvm_programmer_inst.load(`ACT_ADDR, `BSEL_LOW, 8'h05);
        rd_check(`BSEL_LOW, 8'hFF, "first page word");
        // command retained, only the address reloaded
        nvm_programmer_inst.load(`ACT_ADDR, `BSEL_LOW, 8'h85);
        rd_check(`BSEL_HIGH, 8'h12, "retained command read");
        // program two lock bits so that the lock byte differs from the fuse bytes
        nvm_programmer_inst.load(`ACT_CMD, `BSEL_LOW, `CMD_WR_LOCK);
        nvm_programmer_inst.load(`ACT_DATA, `BSEL_LOW, 8'hFC);
        nvm_programmer_inst.write_pulse(`BSEL_LOW);
        wait_ready(200);
        nvm_programmer_inst.load(`ACT_CMD, `BSEL_LOW, `CMD_RD_FUSE);
        for (int b = 0; b < 4; b++) rd_check(2'(b), (b == 1) ? 8'hFC : 8'hFF, "fuse or lock byte");
        flags(8'h06);
        // unknown command, then an idle action that must not load erase
        nvm_programmer_inst.load(`ACT_CMD, `BSEL_LOW, 8'hFF);
        nvm_programmer_inst.load(2'b11, `BSEL_LOW, `CMD_ERASE);
        nvm_programmer_inst.write_pulse(`BSEL_LOW);
        flags(8'h06);
        // a strobe inside the quiet time after high voltage keeps the device out of the mode
        nvm_programmer_inst.enter(1'b1);
        flags(8'h02);
        complete_run();
    end
endmodule : testbench
bind nvm_prog_port nvm_port_sva nvm_port_sva_inst (.clock(clock), .rst_b(rst_b), .pins(pins),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .prog_ready_flag(prog_ready_flag),
    .prog_mode(prog_mode));
